// ===== verilog/tcc_pkg.sv
/*
  constants shared by the compare/capture unit: byte offsets on the
  internal cpu bus, bit positions of control and status fields, reset
  values and the timer phase encoding.
  assumes an 8-bit address, 8-bit data internal bus with one-cycle strobes.
*/
package tcc_pkg;

  localparam logic [7:0] OFS_CAP2_HI  = 8'h0f; // capture2_high_byte
  localparam logic [7:0] OFS_CAP2_LO  = 8'h10; // capture2_low_byte
  localparam logic [7:0] OFS_CONTROL  = 8'h11; // timer control register
  localparam logic [7:0] OFS_STATUS   = 8'h12; // timer status register
  localparam logic [7:0] OFS_CAP1_HI  = 8'h13; // capture1_high_byte
  localparam logic [7:0] OFS_CAP1_LO  = 8'h14; // capture1_low_byte
  localparam logic [7:0] OFS_CMP1_HI  = 8'h15; // compare1_high_byte
  localparam logic [7:0] OFS_CMP1_LO  = 8'h16; // compare1_low_byte
  localparam logic [7:0] OFS_CMP2_HI  = 8'h17; // compare2_high_byte
  localparam logic [7:0] OFS_CMP2_LO  = 8'h18; // compare2_low_byte

  // bit positions: bits 7 to 4 shared by control (enables) and status (flags), the rest control only
  localparam int BIT_CAP1     = 7;
  localparam int BIT_CAP2     = 6;
  localparam int BIT_CMP1     = 5;
  localparam int BIT_CMP2     = 4;
  localparam int BIT_OVF_IE   = 3;
  localparam int BIT_CAP2_EDG = 1;
  localparam int BIT_CAP1_EDG = 0;

  localparam logic [15:0] COUNT_RESET   = 16'hfffc; // counter after reset
  localparam logic [7:0]  CONTROL_RESET = 8'h00;    // enables after reset
  localparam logic [7:0]  READ_IDLE     = 8'h00;    // unmapped read value
  localparam logic [1:0]  PHASE_RESET   = 2'h0;     // prescaler after reset

  // prescaler phases of one counter count
  typedef enum logic [1:0] {
    TCC_T00 = 2'b00,
    TCC_T01 = 2'b01,
    TCC_T10 = 2'b10,
    TCC_T11 = 2'b11
  } tcc_phase_t;

endpackage : tcc_pkg

// ===== verilog/tcc_cap_chan.sv
/*
  one capture input: three-stage pin synchroniser, edge qualifier and
  a counter pipeline aligned with the synchroniser.
  assumes the pin is asynchronous to ref_clk and the counter is on ref_clk.
*/
`timescale 1ns/1ps
module tcc_cap_chan
  import tcc_pkg::*;
#(
  parameter int CW = 16                    // counter width
) (
  input  wire logic          ref_clk,      // bus clock
  input  wire logic          arst_n,       // async reset, active low
  input  wire logic          cap_pin,      // raw capture pin
  input  wire logic          edge_select,  // 1 rising, 0 falling
  input  wire logic [CW-1:0] count,        // free-running counter
  output logic               cap_event,    // one-cycle qualifying edge
  output logic [CW-1:0]      cap_value     // value to transfer
);

  logic [2:0]    sync_q, sync_d;           // pin synchroniser stages
  logic          level_q, level_d;         // accepted pin level
  logic [CW-1:0] cnt1_q, cnt1_d;           // counter beside stage one
  logic [CW-1:0] cnt2_q, cnt2_d;           // counter beside stage two
  logic [CW-1:0] cnt3_q, cnt3_d;           // counter beside stage three
  logic          change;                   // stages two and three agree on a new level

  // next values: shift the pin and its time stamp together
  always_comb begin
    sync_d  = {sync_q[1:0], cap_pin};
    cnt1_d  = count;
    cnt2_d  = cnt1_q;
    cnt3_d  = cnt2_q;
    change  = (sync_q[1] == sync_q[2]) && (sync_q[2] != level_q);
    level_d = change ? sync_q[2] : level_q;
  end

  // registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_q  <= 3'h0;
      level_q <= 1'b0;
      cnt1_q  <= '0;
      cnt2_q  <= '0;
      cnt3_q  <= '0;
    end else begin
      sync_q  <= sync_d;
      level_q <= level_d;
      cnt1_q  <= cnt1_d;
      cnt2_q  <= cnt2_d;
      cnt3_q  <= cnt3_d;
    end
  end

  // qualify the direction of the accepted change
  assign cap_event = change && (sync_q[2] == edge_select);
  // stamp taken at the same edge that sampled the pin, plus one
  assign cap_value = cnt3_q + {{(CW-1){1'b0}}, 1'b1};

endmodule : tcc_cap_chan

// ===== verilog/tcc_unit.sv
/*
  timer compare/capture unit: 16-bit free-running counter behind a
  divide-by-four prescaler, two compare channels, two capture channels,
  control and status registers on the internal cpu bus, one irq output.
  assumes single-cycle read and write strobes that never coincide, and
  capture pins asynchronous to ref_clk.
*/
`timescale 1ns/1ps
module tcc_unit
  import tcc_pkg::*;
#(
  parameter int CW = 16                   // counter and register width
) (
  input  wire logic          ref_clk,     // internal bus clock
  input  wire logic          arst_n,      // async reset, active low
  input  wire logic [7:0]    bus_addr,    // byte address
  input  wire logic [7:0]    bus_wdata,   // write data
  input  wire logic          bus_wr,      // write strobe
  input  wire logic          bus_rd,      // read strobe
  output logic [7:0]         bus_rdata,   // read data, next cycle
  input  wire logic          cap1_pin,    // capture 1 input pin
  input  wire logic          cap2_pin,    // capture 2 input pin
  output logic [CW-1:0]      count_value, // free-running counter
  output logic               timer_irq    // timer interrupt request
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  tcc_phase_t    phase_q, phase_d;        // prescaler phase
  logic [CW-1:0] count_q, count_d;        // free-running counter

  logic [7:0]    control_q, control_d;    // enables and edge selects
  logic [7:0]    rdata_q, rdata_d;        // read data register

  logic [CW-1:0] cmp_q [2];               // compare registers, no reset
  logic [CW-1:0] cmp_d [2];               // compare next values
  logic [1:0]    cmp_inhib_q, cmp_inhib_d;// compare stopped after high write
  logic [1:0]    cmp_hit_q, cmp_hit_d;    // match seen in t01
  logic [1:0]    cmp_flag_q, cmp_flag_d;  // compare match flags
  logic [1:0]    cmp_arm_q, cmp_arm_d;    // status read with flag set

  logic [CW-1:0] cap_q [2];               // capture registers, no reset
  logic [CW-1:0] cap_d [2];               // capture next values
  logic [1:0]    cap_inhib_q, cap_inhib_d;// transfer blocked after high read
  logic [1:0]    cap_flag_q, cap_flag_d;  // capture flags
  logic [1:0]    cap_arm_q, cap_arm_d;    // status read with flag set

  logic [1:0]    cap_event;               // qualified edges
  logic [CW-1:0] cap_value [2];           // stamps from the channels
  logic [1:0]    cap_edge_sel;            // edge selects per channel
  logic [1:0]    cap_pins;                // pins per channel

  logic          wr_hit [2][2];           // compare byte writes [ch][hi=1]
  logic [1:0]    cmp_lo_acc;              // compare low byte accessed
  logic [1:0]    cap_hi_rd;               // capture high byte read
  logic [1:0]    cap_lo_acc;              // capture low byte accessed
  logic          status_rd;               // status register read
  logic [7:0]    status_val;              // status register image

  // decode one address against a strobe
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs, input logic s);
    hit = s && (a == ofs);
  endfunction : hit

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  always_comb begin
    wr_hit[0][1]  = hit(bus_addr, OFS_CMP1_HI, bus_wr);
    wr_hit[0][0]  = hit(bus_addr, OFS_CMP1_LO, bus_wr);
    wr_hit[1][1]  = hit(bus_addr, OFS_CMP2_HI, bus_wr);
    wr_hit[1][0]  = hit(bus_addr, OFS_CMP2_LO, bus_wr);
    // low byte accesses, read or write, complete a flag clear
    cmp_lo_acc[0] = hit(bus_addr, OFS_CMP1_LO, bus_wr | bus_rd);
    cmp_lo_acc[1] = hit(bus_addr, OFS_CMP2_LO, bus_wr | bus_rd);
    cap_hi_rd[0]  = hit(bus_addr, OFS_CAP1_HI, bus_rd);
    cap_hi_rd[1]  = hit(bus_addr, OFS_CAP2_HI, bus_rd);
    cap_lo_acc[0] = hit(bus_addr, OFS_CAP1_LO, bus_wr | bus_rd);
    cap_lo_acc[1] = hit(bus_addr, OFS_CAP2_LO, bus_wr | bus_rd);
    status_rd     = hit(bus_addr, OFS_STATUS, bus_rd);
  end

  // status image: flags at their bit positions, other bits zero
  always_comb begin
    status_val           = 8'h00;
    status_val[BIT_CAP1] = cap_flag_q[0];
    status_val[BIT_CAP2] = cap_flag_q[1];
    status_val[BIT_CMP1] = cmp_flag_q[0];
    status_val[BIT_CMP2] = cmp_flag_q[1];
  end

  // ---------------------------------------------------------------
  // prescaler and counter
  // ---------------------------------------------------------------
  // next values: four phases per count, counter steps after t11
  always_comb begin
    count_d = count_q;
    unique case (phase_q)
      TCC_T00: phase_d = TCC_T01;
      TCC_T01: phase_d = TCC_T10;
      TCC_T10: phase_d = TCC_T11;
      TCC_T11: begin
        phase_d = TCC_T00;
        count_d = count_q + {{(CW-1){1'b0}}, 1'b1};
      end
    endcase
  end

  // registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_q <= TCC_T00;
      count_q <= COUNT_RESET;
    end else begin
      phase_q <= phase_d;
      count_q <= count_d;
    end
  end

  assign count_value = count_q;

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  // next value: plain write
  always_comb begin
    control_d = control_q;
    if (hit(bus_addr, OFS_CONTROL, bus_wr)) begin
      control_d = bus_wdata;
    end
  end

  // registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      control_q <= CONTROL_RESET;
    end else begin
      control_q <= control_d;
    end
  end

  // ---------------------------------------------------------------
  // compare registers: no reset, only software writes them
  // ---------------------------------------------------------------
  // next values: each byte written on its own
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      cmp_d[c] = cmp_q[c];
      if (wr_hit[c][1]) begin
        cmp_d[c][15:8] = bus_wdata;
      end
      if (wr_hit[c][0]) begin
        cmp_d[c][7:0] = bus_wdata;
      end
    end
  end

  // storage without reset, contents undefined at power up
  always_ff @(posedge ref_clk) begin
    cmp_q <= cmp_d;
  end

  // ---------------------------------------------------------------
  // compare inhibit, match detect and flags
  // ---------------------------------------------------------------
  // next values per channel
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      // high write stops comparing, low write restarts it
      cmp_inhib_d[c] = cmp_inhib_q[c];
      if (wr_hit[c][1]) begin
        cmp_inhib_d[c] = 1'b1;
      end else if (wr_hit[c][0]) begin
        cmp_inhib_d[c] = 1'b0;
      end
      // equality sampled only in t01
      cmp_hit_d[c] = cmp_hit_q[c];
      if (phase_q == TCC_T01) begin
        cmp_hit_d[c] = !cmp_inhib_q[c] && (cmp_q[c] == count_q);
      end else if (phase_q == TCC_T11) begin
        cmp_hit_d[c] = 1'b0;
      end
      // arm on status read with flag set
      cmp_arm_d[c] = cmp_arm_q[c];
      if (status_rd && cmp_flag_q[c]) begin
        cmp_arm_d[c] = 1'b1;
      end
      // clear on low byte access after arming
      cmp_flag_d[c] = cmp_flag_q[c];
      if (cmp_arm_q[c] && cmp_lo_acc[c]) begin
        cmp_flag_d[c] = 1'b0;
        cmp_arm_d[c]  = 1'b0;
      end
      // setting in t11 wins over a clear in the same cycle
      if (cmp_hit_q[c] && (phase_q == TCC_T11)) begin
        cmp_flag_d[c] = 1'b1;
      end
    end
  end

  // registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmp_inhib_q <= 2'h0;
      cmp_hit_q   <= 2'h0;
      cmp_flag_q  <= 2'h0;
      cmp_arm_q   <= 2'h0;
    end else begin
      cmp_inhib_q <= cmp_inhib_d;
      cmp_hit_q   <= cmp_hit_d;
      cmp_flag_q  <= cmp_flag_d;
      cmp_arm_q   <= cmp_arm_d;
    end
  end

  // ---------------------------------------------------------------
  // capture channels
  // ---------------------------------------------------------------
  assign cap_edge_sel = {control_q[BIT_CAP2_EDG], control_q[BIT_CAP1_EDG]};
  assign cap_pins     = {cap2_pin, cap1_pin};

  // one synchroniser and edge qualifier per pin
  for (genvar g = 0; g < 2; g++) begin : g_cap
    tcc_cap_chan #(
      .CW          (CW)
    ) u_chan (
      .ref_clk     (ref_clk),
      .arst_n      (arst_n),
      .cap_pin     (cap_pins[g]),
      .edge_select (cap_edge_sel[g]),
      .count       (count_q),
      .cap_event   (cap_event[g]),
      .cap_value   (cap_value[g])
    );
  end

  // next values: transfer, inhibit and flag per channel
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      // every qualifying edge transfers unless a high read is pending
      cap_d[c] = cap_q[c];
      if (cap_event[c] && !cap_inhib_q[c]) begin
        cap_d[c] = cap_value[c];
      end
      // high read blocks, low read releases; low read alone never blocks
      cap_inhib_d[c] = cap_inhib_q[c];
      if (cap_hi_rd[c]) begin
        cap_inhib_d[c] = 1'b1;
      end else if (cap_lo_acc[c]) begin
        cap_inhib_d[c] = 1'b0;
      end
      // arm on status read with flag set
      cap_arm_d[c] = cap_arm_q[c];
      if (status_rd && cap_flag_q[c]) begin
        cap_arm_d[c] = 1'b1;
      end
      cap_flag_d[c] = cap_flag_q[c];
      if (cap_arm_q[c] && cap_lo_acc[c]) begin
        cap_flag_d[c] = 1'b0;
        cap_arm_d[c]  = 1'b0;
      end
      // edge wins over a clear in the same cycle
      if (cap_event[c]) begin
        cap_flag_d[c] = 1'b1;
      end
    end
  end

  // capture storage without reset, read only from the bus
  always_ff @(posedge ref_clk) begin
    cap_q <= cap_d;
  end

  // capture control registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cap_inhib_q <= 2'h0;
      cap_flag_q  <= 2'h0;
      cap_arm_q   <= 2'h0;
    end else begin
      cap_inhib_q <= cap_inhib_d;
      cap_flag_q  <= cap_flag_d;
      cap_arm_q   <= cap_arm_d;
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  // next value: sampled on the read strobe, held otherwise
  always_comb begin
    rdata_d = rdata_q;
    if (bus_rd) begin
      unique case (bus_addr)
        OFS_CAP2_HI: rdata_d = cap_q[1][15:8];
        OFS_CAP2_LO: rdata_d = cap_q[1][7:0];
        OFS_CONTROL: rdata_d = control_q;
        OFS_STATUS:  rdata_d = status_val;
        OFS_CAP1_HI: rdata_d = cap_q[0][15:8];
        OFS_CAP1_LO: rdata_d = cap_q[0][7:0];
        OFS_CMP1_HI: rdata_d = cmp_q[0][15:8];
        OFS_CMP1_LO: rdata_d = cmp_q[0][7:0];
        OFS_CMP2_HI: rdata_d = cmp_q[1][15:8];
        OFS_CMP2_LO: rdata_d = cmp_q[1][7:0];
        default:     rdata_d = READ_IDLE;      // unmapped reads zero
      endcase
    end
  end

  // registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= READ_IDLE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign bus_rdata = rdata_q;

  // ---------------------------------------------------------------
  // interrupt request: any flag with its enable
  // ---------------------------------------------------------------
  assign timer_irq = (cmp_flag_q[0] && control_q[BIT_CMP1])
                   || (cmp_flag_q[1] && control_q[BIT_CMP2])
                   || (cap_flag_q[0] && control_q[BIT_CAP1])
                   || (cap_flag_q[1] && control_q[BIT_CAP2]);

endmodule : tcc_unit

// ===== bench/tcc_unit_checker.sv
/*
  port-level assertions and covers for the compare/capture unit.
  assumes the register map of tcc_pkg and one-cycle bus strobes.
*/
`timescale 1ns/1ps
module tcc_unit_checker
  import tcc_pkg::*;
#(
  parameter int CW = 16                   // counter width
) (
  input wire logic          ref_clk,      // bus clock
  input wire logic          arst_n,       // async reset, active low
  input wire logic [7:0]    bus_addr,     // byte address
  input wire logic [7:0]    bus_wdata,    // write data
  input wire logic          bus_wr,       // write strobe
  input wire logic          bus_rd,       // read strobe
  input wire logic [7:0]    bus_rdata,    // read data
  input wire logic          cap1_pin,     // capture pin 1
  input wire logic          cap2_pin,     // capture pin 2
  input wire logic [CW-1:0] count_value,  // counter
  input wire logic          timer_irq     // interrupt request
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  logic [7:0] ctrl_q;  // shadow of the control register
  logic [7:0] ctrl_d;
  logic [7:0] cmp1h_q; // shadow of compare1 high byte, never reset
  logic [7:0] cmp1h_d;
  logic       seen_q;  // compare1 high byte written since reset
  logic       seen_d;

  // next values of the shadows from bus writes
  always_comb begin
    ctrl_d  = ctrl_q;
    cmp1h_d = cmp1h_q;
    seen_d  = seen_q;
    if (bus_wr && bus_addr == OFS_CONTROL) begin
      ctrl_d = bus_wdata;
    end
    if (bus_wr && bus_addr == OFS_CMP1_HI) begin
      cmp1h_d = bus_wdata;
      seen_d  = 1'b1;
    end
  end

  // control shadow and seen mark follow reset
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= CONTROL_RESET;
      seen_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      seen_q <= seen_d;
    end
  end

  // compare shadow keeps its value through reset, like the register
  always_ff @(posedge ref_clk) begin
    cmp1h_q <= cmp1h_d;
  end

  chk_count_step: assert property ($changed(count_value) |-> count_value == CW'($past(count_value) + 1'b1))
    else $error("counter moved by other than one");
  chk_count_pace: assert property ($changed(count_value) |=> $stable(count_value) [*3] ##1 $changed(count_value))
    else $error("counter did not step every four clocks");
  chk_rdata_hold: assert property (!bus_rd |=> $stable(bus_rdata))
    else $error("read data moved without a read");
  chk_unmapped_zero: assert property (bus_rd && (bus_addr < OFS_CAP2_HI || bus_addr > OFS_CMP2_LO) |=> bus_rdata == READ_IDLE)
    else $error("unmapped read not idle value");
  chk_status_low: assert property (bus_rd && bus_addr == OFS_STATUS |=> bus_rdata[3:0] == 4'h0)
    else $error("status low bits not zero");
  chk_ctrl_readback: assert property (bus_rd && bus_addr == OFS_CONTROL |=> bus_rdata == $past(ctrl_q))
    else $error("control read back wrong");
  chk_irq_masked: assert property (ctrl_q[7:4] == 4'h0 |-> !timer_irq)
    else $error("irq with all enables clear");
  chk_irq_fall: assert property ($fell(timer_irq) |-> $past(bus_rd) || $past(bus_wr))
    else $error("irq dropped without a bus access");
  chk_cmp_readback: assert property (bus_rd && bus_addr == OFS_CMP1_HI && seen_q |=> bus_rdata == $past(cmp1h_q))
    else $error("compare high byte read back wrong");

  cov_irq_rise: cover property ($rose(timer_irq));
  cov_status_set: cover property (bus_rd && bus_addr == OFS_STATUS ##1 bus_rdata != 8'h00);
  cov_cmp_write: cover property (bus_wr && bus_addr == OFS_CMP2_HI);
endmodule : tcc_unit_checker

bind tcc_unit tcc_unit_checker #(.CW(CW)) tcc_unit_checker_inst (
  .ref_clk    (ref_clk),
  .arst_n     (arst_n),
  .bus_addr   (bus_addr),
  .bus_wdata  (bus_wdata),
  .bus_wr     (bus_wr),
  .bus_rd     (bus_rd),
  .bus_rdata  (bus_rdata),
  .cap1_pin   (cap1_pin),
  .cap2_pin   (cap2_pin),
  .count_value(count_value),
  .timer_irq  (timer_irq)
);

// ===== bench/tcc_pin_model.sv
/*
  external capture sources: the two pins follow the bench's requests
  after a fixed skew.
  assumes requests change just after a rising edge of ref_clk.
*/
`timescale 1ns/1ps
module tcc_pin_model #(
  parameter int SKEW_NS = 37      // pin delay, keeps edges off the clock
) (
  input  wire logic pin1_req,     // wanted level of pin 1
  input  wire logic pin2_req,     // wanted level of pin 2
  output logic      cap1_pin,     // capture pin 1
  output logic      cap2_pin      // capture pin 2
);
  // pins start low, as a quiet source would
  initial begin
    cap1_pin = 1'b0;
    cap2_pin = 1'b0;
  end

  // pins follow requests late, asynchronous to the bus clock
  always @(pin1_req) cap1_pin <= #(SKEW_NS) pin1_req;
  always @(pin2_req) cap2_pin <= #(SKEW_NS) pin2_req;
endmodule : tcc_pin_model

// ===== bench/tcc_unit_tb_top.sv
/*
  self-checking bench for the compare/capture unit.
  assumes a 10 MHz ref_clk and the pin model for the capture pins.
*/
`timescale 1ns/1ps
module tcc_unit_tb_top;
  import tcc_pkg::*;
  logic        ref_clk, arst_n, bus_wr, bus_rd, timer_irq;   // control and irq
  logic        pin1_req, pin2_req, cap1_pin, cap2_pin;      // pin requests and pins
  logic [7:0]  bus_addr, bus_wdata, bus_rdata;              // bus fields
  logic [15:0] count_value;                                 // counter
  int          cyc, fail_count, comparisons;                // edges since release, tallies

  tcc_unit #(.CW(16)) tcc_unit_inst (.ref_clk(ref_clk), .arst_n(arst_n), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .cap1_pin(cap1_pin),
    .cap2_pin(cap2_pin), .count_value(count_value), .timer_irq(timer_irq));
  tcc_pin_model tcc_pin_model_inst (.pin1_req(pin1_req), .pin2_req(pin2_req), .cap1_pin(cap1_pin),
    .cap2_pin(cap2_pin));

  // 100 ns clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // edge count since reset release gives the expected counter
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) cyc <= 0;
    else cyc <= cyc + 1;
  end

  function automatic logic [15:0] ecnt();
    ecnt = COUNT_RESET + 16'(cyc / 4);
  endfunction : ecnt

  task automatic summarize();
    if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_flag(input logic got, input logic exp);
    chk_val({15'h0000, got}, {15'h0000, exp});
  endtask : chk_flag

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_wr    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    bus_rd   <= 1'b1;
    bus_addr <= a;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    #1 d = bus_rdata;
  endtask : rd

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk_val({8'h00, d}, {8'h00, exp});
  endtask : rd_chk

  task automatic cap_chk(input logic [7:0] ha, input logic [7:0] la, input logic [15:0] exp);
    logic [7:0] h, l;
    rd(ha, h);
    rd(la, l);
    chk_val({h, l}, exp);
  endtask : cap_chk

  // bounded wait until the counter holds c
  task automatic until_count(input logic [15:0] c);
    int i;
    for (i = 0; i < 400 && ecnt() != c; i++) begin
      @(posedge ref_clk);
      #1;
    end
    if (i == 400) begin
      fail_count++;
      summarize();
    end
  endtask : until_count

  // move a pin one cycle into a count, then let the synchroniser settle
  task automatic cap_edge(input int ch, input logic v, output logic [15:0] e);
    for (int i = 0; i < 4 && cyc % 4 != 1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    e = ecnt() + 16'd1;
    if (ch == 1) pin1_req = v;
    else pin2_req = v;
    repeat (8) @(posedge ref_clk);
    #1;
  endtask : cap_edge

  task automatic do_reset();
    @(posedge ref_clk);
    arst_n <= 1'b0;
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    #1;
  endtask : do_reset

  // compare bytes are independent and survive reset
  task automatic t_bytes();
    wr(OFS_CMP1_HI, 8'h12);
    wr(OFS_CMP1_LO, 8'h34);
    wr(OFS_CMP2_HI, 8'hab);
    wr(OFS_CMP2_LO, 8'hcd);
    wr(OFS_CMP1_LO, 8'h77);
    rd_chk(OFS_CMP1_HI, 8'h12);
    rd_chk(OFS_CMP1_LO, 8'h77);
    do_reset();
    chk_val(count_value, COUNT_RESET);
    rd_chk(OFS_CMP1_HI, 8'h12);
    rd_chk(OFS_CMP2_LO, 8'hcd);
  endtask : t_bytes

  // control reset value, readback, unmapped reads
  task automatic t_regs();
    rd_chk(OFS_CONTROL, CONTROL_RESET);
    rd_chk(OFS_STATUS, 8'h00);
    rd_chk(8'h00, READ_IDLE);
    rd_chk(8'h19, READ_IDLE);
    wr(OFS_CONTROL, 8'hfb);
    rd_chk(OFS_CONTROL, 8'hfb);
    chk_flag(timer_irq, 1'b0);
    wr(OFS_CONTROL, 8'h00);
  endtask : t_regs

  // compare match timing, flag position, irq and clearing
  task automatic t_compare();
    logic [15:0] tgt;
    logic [7:0]  s;
    wr(OFS_CONTROL, 8'h20);
    tgt = ecnt() + 16'd12;
    wr(OFS_CMP1_HI, tgt[15:8]);
    rd(OFS_STATUS, s);
    wr(OFS_CMP1_LO, tgt[7:0]);
    until_count(tgt);
    repeat (3) @(posedge ref_clk);
    #1 chk_flag(timer_irq, 1'b0);
    @(posedge ref_clk);
    #1 chk_flag(timer_irq, 1'b1);
    rd_chk(OFS_STATUS, 8'h20);
    chk_flag(timer_irq, 1'b1);
    rd_chk(OFS_CMP1_LO, tgt[7:0]);
    chk_flag(timer_irq, 1'b0);
  endtask : t_compare

  // high byte write inhibits, low byte write alone does not
  task automatic t_inhibit();
    logic [15:0] tgt;
    wr(OFS_CONTROL, 8'h10);
    tgt = ecnt() + 16'd10;
    wr(OFS_CMP2_LO, tgt[7:0]);
    wr(OFS_CMP2_HI, tgt[15:8]);
    until_count(tgt + 16'd2);
    chk_flag(timer_irq, 1'b0);
    wr(OFS_CMP2_LO, 8'(ecnt() - 16'd1));
    tgt = ecnt() + 16'd10;
    wr(OFS_CMP2_LO, tgt[7:0]);
    until_count(tgt + 16'd2);
    chk_flag(timer_irq, 1'b1);
    rd_chk(OFS_STATUS, 8'h10);
    rd_chk(OFS_CMP2_LO, tgt[7:0]);
    chk_flag(timer_irq, 1'b0);
  endtask : t_inhibit

  // capture 1 on rising edges: value, overwrite, blocking, clear
  task automatic t_capture();
    logic [15:0] e1, e2, e3;
    logic [7:0]  h;
    wr(OFS_CONTROL, 8'h81);
    cap_edge(1, 1'b1, e1);
    chk_flag(timer_irq, 1'b1);
    wr(OFS_CAP1_HI, ~e1[15:8]);
    cap_chk(OFS_CAP1_HI, OFS_CAP1_LO, e1);
    cap_edge(1, 1'b0, e3);
    cap_edge(1, 1'b1, e2);
    cap_chk(OFS_CAP1_HI, OFS_CAP1_LO, e2);
    cap_edge(1, 1'b0, e3);
    rd(OFS_CAP1_HI, h);
    cap_edge(1, 1'b1, e3);
    rd_chk(OFS_CAP1_LO, e2[7:0]);
    rd_chk(OFS_STATUS, 8'h80);
    rd_chk(OFS_CAP1_LO, e2[7:0]);
    chk_flag(timer_irq, 1'b0);
  endtask : t_capture

  // capture 2 on a falling edge only, then the other edge selects
  task automatic t_cap2();
    logic [15:0] e;
    wr(OFS_CONTROL, 8'h40);
    cap_edge(2, 1'b1, e);
    chk_flag(timer_irq, 1'b0);
    cap_edge(2, 1'b0, e);
    chk_flag(timer_irq, 1'b1);
    cap_chk(OFS_CAP2_HI, OFS_CAP2_LO, e);
    rd_chk(OFS_STATUS, 8'h40);
    rd_chk(OFS_CAP2_LO, e[7:0]);
    chk_flag(timer_irq, 1'b0);
    cap_edge(1, 1'b0, e);
    cap_chk(OFS_CAP1_HI, OFS_CAP1_LO, e);
    wr(OFS_CONTROL, 8'h02);
    cap_edge(2, 1'b1, e);
    cap_chk(OFS_CAP2_HI, OFS_CAP2_LO, e);
  endtask : t_cap2

  // run limit
  initial begin
    repeat (100000) @(posedge ref_clk);
    fail_count++;
    summarize();
  end

  // main sequence
  initial begin
    fail_count  = 0;
    comparisons = 0;
    arst_n      = 1'b0;
    bus_wr      = 1'b0;
    bus_rd      = 1'b0;
    bus_addr    = 8'h00;
    bus_wdata   = 8'h00;
    pin1_req    = 1'b0;
    pin2_req    = 1'b0;
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_bytes();
    t_regs();
    t_compare();
    t_inhibit();
    t_capture();
    t_cap2();
    summarize();
  end
endmodule : tcc_unit_tb_top
